// ---- design/icr_slave.sv ----
`timescale 1ns/1ps
`default_nettype none
module icr_slave (
  input wire logic mclk,
  input wire logic reset,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic [2:0] addr_strap,
  output logic cfg_wr,
  output logic cfg_rd,
  output logic [3:0] cfg_port,
  output logic [11:0] cfg_addr,
  output logic [3:0] cfg_be,
  output logic [31:0] cfg_wdata,
  input wire logic [31:0] cfg_rdata
);
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_RX = 5'b00010,
    ST_ACK = 5'b00100,
    ST_TX = 5'b01000,
    ST_RACK = 5'b10000
  } icr_state_t;

  logic scl_s;
  logic sda_s;
  icr_sync u_scl (.mclk(mclk), .reset(reset), .d(scl_i), .q(scl_s));
  icr_sync u_sda (.mclk(mclk), .reset(reset), .d(sda_i), .q(sda_s));
  logic [2:0] strap_s;
  for (genvar g = 0; g < icr_pkg::STRAP_W; g++)
  begin : g_strap
    icr_sync u_strap (.mclk(mclk), .reset(reset), .d(addr_strap[g]),
      .q(strap_s[g]));
  end

  logic scl_q, sda_q;
  logic rise, fall, start_c, stop_c;
  icr_state_t st_q, st_d;
  logic [2:0] bit_q, bit_d;
  logic [7:0] sh_q, sh_d;
  logic [2:0] idx_q, idx_d;
  logic rd_q, rd_d;
  logic drv_q, drv_d;
  logic nack_q, nack_d;
  logic [31:0] cmd_q, cmd_d;
  logic [31:0] wbuf_q, wbuf_d;
  logic [31:0] rbuf_q, rbuf_d;
  logic [1:0] rsel_q, rsel_d;
  logic wr_q, wr_d, rdp_q, rdp_d;
  logic addr_hit;
  logic full_q, full_d, head_q, head_d;

  function automatic logic [7:0] pick_byte(input logic [31:0] w,
                                           input logic [1:0] s);
    pick_byte = w[(icr_pkg::BYTE_BITS - s) * 8 +: 8];
  endfunction : pick_byte

  assign rise = scl_s && !scl_q;
  assign fall = !scl_s && scl_q;
  assign start_c = scl_s && scl_q && sda_q && !sda_s;
  assign stop_c = scl_s && scl_q && !sda_q && sda_s;
  assign addr_hit = sh_q[7:1] ==
    {icr_pkg::BASE_ADDR[6:3], strap_s};

  always_comb
  begin
    st_d = st_q;
    bit_d = bit_q;
    sh_d = sh_q;
    idx_d = idx_q;
    rd_d = rd_q;
    drv_d = drv_q;
    nack_d = nack_q;
    cmd_d = cmd_q;
    wbuf_d = wbuf_q;
    rbuf_d = rbuf_q;
    rsel_d = rsel_q;
    full_d = full_q;
    head_d = head_q;
    wr_d = 1'b0;
    rdp_d = 1'b0;
    if (rdp_q)
      rbuf_d = cfg_rdata;
    if (stop_c)
    begin
      st_d = ST_IDLE;
      drv_d = 1'b0;
    end
    else if (start_c)
    begin
      st_d = ST_RX;
      bit_d = 3'h0;
      idx_d = 3'h7;
      full_d = 1'b0;
      head_d = 1'b1;
      drv_d = 1'b0;
    end
    else
    begin
      unique case (st_q)
        ST_IDLE:
        begin
          drv_d = 1'b0;
        end
        ST_RX:
        begin
          if (rise)
          begin
            sh_d = {sh_q[6:0], sda_s};
            bit_d = bit_q + 3'h1;
            full_d = bit_q == 3'h7;
          end
          else if (fall && full_q)
          begin
            full_d = 1'b0;
            head_d = 1'b0;
            if (head_q)
            begin
              if (addr_hit)
              begin
                rd_d = sh_q[0];
                st_d = ST_ACK;
                drv_d = 1'b1;
                nack_d = 1'b0;
                idx_d = 3'h0;
                rsel_d = 2'h0;
              end
              else
                st_d = ST_IDLE;
            end
            else if (idx_q <= icr_pkg::CMD_LAST)
            begin
              cmd_d = {cmd_q[23:0], sh_q};
              st_d = ST_ACK;
              drv_d = 1'b1;
              nack_d = 1'b0;
              if (idx_q == icr_pkg::CMD_LAST &&
                  cmd_d[26:24] == icr_pkg::OP_READ)
                rdp_d = 1'b1;
              idx_d = idx_q + 3'h1;
            end
            else
            begin
              wbuf_d = {wbuf_q[23:0], sh_q};
              st_d = ST_ACK;
              drv_d = 1'b1;
              nack_d = idx_q == icr_pkg::BCNT_LAST;
              if (idx_q == icr_pkg::BCNT_LAST &&
                  !nack_q && cmd_q[26:24] == icr_pkg::OP_WRITE)
                wr_d = 1'b1;
              if (idx_q != icr_pkg::BCNT_LAST)
                idx_d = idx_q + 3'h1;
            end
          end
        end
        ST_ACK:
        begin
          if (fall)
          begin
            bit_d = 3'h0;
            sh_d = 8'h00;
            if (rd_q && idx_q == 3'h0)
            begin
              st_d = ST_TX;
              sh_d = pick_byte(rbuf_q, rsel_q);
              drv_d = !sh_d[7];
            end
            else
            begin
              st_d = ST_RX;
              drv_d = 1'b0;
            end
          end
        end
        ST_TX:
        begin
          if (fall)
          begin
            bit_d = bit_q + 3'h1;
            sh_d = {sh_q[6:0], 1'b0};
            drv_d = !sh_d[7];
            if (bit_q == 3'h7)
            begin
              st_d = ST_RACK;
              drv_d = 1'b0;
              rsel_d = rsel_q + 2'h1;
            end
          end
        end
        ST_RACK:
        begin
          if (rise && sda_s)
            st_d = ST_IDLE;
          else if (rise)
            st_d = ST_ACK;
        end
        default:
          st_d = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      st_q <= ST_IDLE;
      bit_q <= 3'h0;
      sh_q <= 8'h00;
      idx_q <= 3'h7;
      rd_q <= 1'b0;
      drv_q <= 1'b0;
      nack_q <= 1'b0;
      cmd_q <= 32'h0;
      wbuf_q <= 32'h0;
      rbuf_q <= 32'h0;
      rsel_q <= 2'h0;
      wr_q <= 1'b0;
      rdp_q <= 1'b0;
      full_q <= 1'b0;
      head_q <= 1'b0;
    end
    else
    begin
      scl_q <= scl_s;
      sda_q <= sda_s;
      st_q <= st_d;
      bit_q <= bit_d;
      sh_q <= sh_d;
      idx_q <= idx_d;
      rd_q <= rd_d;
      drv_q <= drv_d;
      nack_q <= nack_d;
      cmd_q <= cmd_d;
      wbuf_q <= wbuf_d;
      rbuf_q <= rbuf_d;
      rsel_q <= rsel_d;
      wr_q <= wr_d;
      rdp_q <= rdp_d;
      full_q <= full_d;
      head_q <= head_d;
    end
  end

  assign sda_o = 1'b0;
  assign sda_oe = drv_q && !(st_q == ST_ACK && nack_q);
  assign cfg_wr = wr_q;
  assign cfg_rd = rdp_q;
  assign cfg_port = {cmd_q[18:16], cmd_q[15]};
  assign cfg_addr = {cmd_q[9:8], cmd_q[7:0], 2'h0};
  assign cfg_be = cmd_q[13:10];
  assign cfg_wdata = wbuf_q;

  a_read_fetch: assert property (@(posedge mclk) disable iff (reset)
    cfg_rd |=> rbuf_q == $past(cfg_rdata))
    else $error("read buffer not loaded");
  a_write_op: assert property (@(posedge mclk) disable iff (reset)
    cfg_wr |-> cmd_q[26:24] == icr_pkg::OP_WRITE)
    else $error("write with bad command");
  a_nack_last: assert property (@(posedge mclk) disable iff (reset)
    $rose(wr_q) |-> $past(nack_d))
    else $error("fourth data byte acked");
  a_dir_bit: assert property (@(posedge mclk) disable iff (reset)
    st_q == ST_TX |-> rd_q)
    else $error("transmit on write transfer");
  sequence s_addr_match;
    st_q == ST_RX && fall && full_q && head_q && addr_hit;
  endsequence
  a_addr_ack: assert property (@(posedge mclk) disable iff (reset)
    s_addr_match |=> st_q == ST_ACK && sda_oe)
    else $error("own address not acked");
  a_read_wrap: assert property (@(posedge mclk) disable iff (reset)
    st_q == ST_TX && fall && bit_q == 3'h7 |=> rsel_q == $past(rsel_q) + 2'h1)
    else $error("read byte select not advanced");
endmodule : icr_slave
`default_nettype wire

// ---- design/icr_pkg.sv ----
package icr_pkg;
  localparam int BYTE_W = 8;
  localparam int WORD_W = 32;
  localparam int ADDR_W = 10;
  localparam logic [6:0] BASE_ADDR = 7'h3F;
  localparam logic [2:0] OP_WRITE = 3'h3;
  localparam logic [2:0] OP_READ = 3'h4;
  localparam logic [2:0] BCNT_LAST = 3'h7;
  localparam logic [2:0] CMD_LAST = 3'h3;
  localparam logic [2:0] WDATA_LAST = 3'h3;
  localparam logic [1:0] RD_LAST = 2'h3;
  localparam logic [1:0] BYTE_BITS = 2'h3;
  localparam logic [3:0] STRAP_W = 4'h3;
endpackage : icr_pkg

// ---- design/icr_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module icr_sync (
  input wire logic mclk,
  input wire logic reset,
  input wire logic d,
  output logic q
);
  logic s1_q;
  logic s2_q;
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
    end
    else
    begin
      s1_q <= d;
      s2_q <= s1_q;
    end
  end
  assign q = s2_q;
endmodule : icr_sync
`default_nettype wire

// ---- verif/icr_master.sv ----
`timescale 1ns/1ps
`default_nettype none
module icr_master (
  input wire logic mclk,
  input wire logic sda,
  output logic scl,
  output logic pull
);
  initial
  begin
    scl = 1'b1;
    pull = 1'b0;
  end
  task automatic qp;
    repeat (4) @(negedge mclk);
  endtask : qp
  // Also a repeated start when the clock is low
  task automatic start;
    pull = 1'b0;
    qp();
    scl = 1'b1;
    qp();
    pull = 1'b1;
    qp();
    scl = 1'b0;
    qp();
  endtask : start
  task automatic stop;
    pull = 1'b1;
    qp();
    scl = 1'b1;
    qp();
    pull = 1'b0;
    qp();
  endtask : stop
  // Eight bits and the ninth; a one leaves the line to the pull-up
  task automatic xfer(input logic [8:0] w, output logic [8:0] r);
    for (int i = 8; i >= 0; i--)
    begin
      pull = ~w[i];
      qp();
      scl = 1'b1;
      qp();
      r[i] = sda;
      qp();
      scl = 1'b0;
      qp();
    end
  endtask : xfer
endmodule : icr_master
`default_nettype wire

// ---- verif/tb_i2c_config_register_access_slave.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_i2c_config_register_access_slave;
  logic mclk;
  logic reset;
  logic scl;
  logic pull;
  logic sda_oe;
  logic sda_o;
  logic sda;
  logic [2:0] strap;
  logic cfg_wr;
  logic cfg_rd;
  logic [3:0] cfg_port;
  logic [11:0] cfg_addr;
  logic [3:0] cfg_be;
  logic [31:0] cfg_wdata;
  logic [31:0] cfg_rdata;
  logic [2:0] op;
  logic [3:0] port;
  logic [9:0] ra;
  logic [3:0] be;
  logic [31:0] wd;
  logic [8:0] r;
  logic [8:0] acks;
  logic [51:0] wr_got;
  logic [15:0] rd_got;
  int seed = 22;
  int failures = 0;
  int samples_checked = 0;
  int wr_n;
  int rd_n;
  assign sda = ~pull & (sda_oe ? sda_o : 1'b1);
  icr_slave dut (
    .mclk(mclk), .reset(reset), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe(sda_oe), .addr_strap(strap), .cfg_wr(cfg_wr),
    .cfg_rd(cfg_rd), .cfg_port(cfg_port), .cfg_addr(cfg_addr),
    .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata)
  );
  icr_master m (.mclk(mclk), .sda(sda), .scl(scl), .pull(pull));
  always @(posedge mclk)
  begin
    if (cfg_wr)
    begin
      wr_n++;
      wr_got <= {cfg_port, cfg_addr, cfg_be, cfg_wdata};
    end
    if (cfg_rd)
    begin
      rd_n++;
      rd_got <= {cfg_port, cfg_addr};
    end
  end
  function automatic logic [7:0] pkt(input int i);
    case (i)
      0: pkt = 8'h7E;
      1: pkt = {5'h00, op};
      2: pkt = {5'h00, port[3:1]};
      3: pkt = {port[0], 1'b0, be, ra[9:8]};
      4: pkt = ra[7:0];
      default: pkt = wd[31 - 8 * (i - 5) -: 8];
    endcase
  endfunction : pkt
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask : chk
  task automatic head(input int n);
    m.start();
    for (int i = 0; i < n; i++)
    begin
      m.xfer({pkt(i), 1'b1}, r);
      acks[i] = r[0];
    end
  endtask : head
  task automatic wr_test(input logic [2:0] code);
    op = code;
    wr_n = 0;
    head(9);
    m.stop();
    if (code == 3'h3)
    begin
      chk(acks, 9'h100);
      chk(wr_got, {port, ra, 2'b00, be, wd});
    end
    chk(wr_n, code == 3'h3);
    $display("write test op %0h done", code);
  endtask : wr_test
  task automatic rd_test(input logic rs);
    op = 3'h4;
    cfg_rdata = 32'($random(seed));
    rd_n = 0;
    head(5);
    chk(acks[4:0], 5'h00);
    if (!rs) m.stop();
    m.start();
    m.xfer(9'h0FF, r);
    chk(r[0], 1'b0);
    for (int k = 0; k < 6; k++)
    begin
      m.xfer({8'hFF, k == 5}, r);
      chk(r[8:1], cfg_rdata[31 - 8 * (k % 4) -: 8]);
    end
    m.stop();
    chk({rd_n, rd_got}, {32'd1, port, ra, 2'b00});
    $display("read test done");
  endtask : rd_test
  task automatic wrap_up;
    $display("checked %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : wrap_up
  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  initial
  begin
    repeat (80000) @(posedge mclk);
    failures++;
    wrap_up();
  end
  initial
  begin
    reset = 1'b1;
    strap = 3'h7;
    cfg_rdata = 32'h0;
    port = 4'h7;
    ra = 10'h014;
    be = 4'hF;
    wd = 32'h12345678;
    repeat (8) @(negedge mclk);
    reset = 1'b0;
    repeat (4) @(negedge mclk);
    wr_test(3'h3);
    strap = 3'h0;
    m.start();
    m.xfer(9'h0FD, r);
    chk(r[0], 1'b1);
    m.stop();
    strap = 3'h7;
    $display("address test done");
    for (int t = 0; t < 6; t++)
    begin
      port = 4'($random(seed));
      ra = 10'($random(seed));
      be = 4'($random(seed));
      wd = 32'($random(seed));
      rd_test(t[0]);
      wr_test(3'h3);
      wr_test(t < 3 ? 3'(t) : 3'(t + 2));
    end
    wrap_up();
  end
endmodule : tb_i2c_config_register_access_slave
`default_nettype wire
